// ===== shared/cptg_pkg.sv
// cptg_pkg: constants, modes and carrier structs of the pulse train generator
// assumes: included first; used by the generator and its sample fifo
package cptg_pkg;

  localparam int CPTG_CNT_W = 32;
  localparam int CPTG_FIFO_DEPTH = 32;
  localparam int CPTG_PTR_W = 5;
  localparam logic [CPTG_CNT_W-1:0] CPTG_ZERO = 32'h0000_0000;
  localparam logic [CPTG_CNT_W-1:0] CPTG_ONE = 32'h0000_0001;
  localparam logic [CPTG_PTR_W:0] CPTG_LVL_ZERO = 6'h00;
  localparam logic [CPTG_PTR_W:0] CPTG_LVL_ONE = 6'h01;
  localparam logic [CPTG_PTR_W-1:0] CPTG_PTR_ONE = 5'h01;
  localparam logic [CPTG_PTR_W-1:0] CPTG_PTR_ZERO = 5'h00;

  // generation modes
  typedef enum logic [2:0] {
    CPTG_MODE_SINGLE = 3'h0,
    CPTG_MODE_FINITE = 3'h1,
    CPTG_MODE_CONT = 3'h2,
    CPTG_MODE_IMPLICIT = 3'h3,
    CPTG_MODE_SAMPCLK = 3'h4
  } cptg_mode_e;

  // how the gate input is used
  typedef enum logic [1:0] {
    CPTG_GATE_NONE = 2'h0,
    CPTG_GATE_START = 2'h1,
    CPTG_GATE_PAUSE = 2'h2
  } cptg_gate_e;

  // sample supply for buffered modes
  typedef enum logic [1:0] {
    CPTG_SUP_HOST = 2'h0,
    CPTG_SUP_FIFO_REGEN = 2'h1,
    CPTG_SUP_NONREGEN = 2'h2
  } cptg_sup_e;

  // gray-coded along idle -> wait -> delay -> idle phase -> active phase
  typedef enum logic [2:0] {
    CPTG_ST_OFF = 3'b000,
    CPTG_ST_WAIT = 3'b001,
    CPTG_ST_DELAY = 3'b011,
    CPTG_ST_LOW = 3'b010,
    CPTG_ST_HIGH = 3'b110,
    CPTG_ST_DONE = 3'b111
  } cptg_state_e;

  // one buffered pulse specification
  typedef struct packed {
    logic [CPTG_CNT_W-1:0] idle_ticks;
    logic [CPTG_CNT_W-1:0] active_ticks;
  } cptg_spec_s;

  localparam int CPTG_SPEC_W = 2 * CPTG_CNT_W;

  // static channel settings
  typedef struct packed {
    cptg_mode_e mode;
    cptg_gate_e gate_use;
    cptg_sup_e supply;
    logic src_falling;
    logic retrigger;
    logic delay_on_every_trigger;
    logic finite_buf;
    logic [CPTG_CNT_W-1:0] init_delay;
    logic [CPTG_CNT_W-1:0] low_ticks;
    logic [CPTG_CNT_W-1:0] high_ticks;
    logic [CPTG_CNT_W-1:0] pulse_count;
  } cptg_cfg_s;

endpackage

// ===== verilog/cptg_generator.sv
// cptg_generator: counter pulse train engine with sample fifo
// assumes: source, gate and sample clock are asynchronous pins; cfg is
// held stable while armed; sample words come from logic on clock_i
`timescale 1ns/1ps

// --------------------------------------------------------------------
// sample fifo
// --------------------------------------------------------------------
module cptg_fifo
  import cptg_pkg::*;
#(
  parameter int WIDTH = 64,
  parameter int DEPTH = 32,
  parameter int PTR_W = 5
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic flush_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  // level
  output logic [PTR_W:0] level_o
);

  typedef struct packed {
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0] level;
  } cptg_fifo_s;

  logic [WIDTH-1:0] mem [DEPTH];
  cptg_fifo_s st;
  cptg_fifo_s next_st;
  logic push;
  logic pop;

  // a full fifo still takes a word in the cycle it gives one out
  assign in_ready_o = ((st.level != (PTR_W+1)'(DEPTH)) || out_ready_i)
                   && !flush_i;
  assign out_valid_o = (st.level != CPTG_LVL_ZERO) && !flush_i;
  assign out_data_o = mem[st.rd_ptr];
  assign level_o = st.level;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    next_st = st;
    if (flush_i) begin
      next_st = '0;
    end else begin
      if (push) begin
        next_st.wr_ptr = st.wr_ptr + CPTG_PTR_ONE;
      end
      if (pop) begin
        next_st.rd_ptr = st.rd_ptr + CPTG_PTR_ONE;
      end
      if (push && !pop) begin
        next_st.level = st.level + CPTG_LVL_ONE;
      end else if (pop && !push) begin
        next_st.level = st.level - CPTG_LVL_ONE;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
    if (push) begin
      mem[st.wr_ptr] <= in_data_i;
    end
  end
endmodule

// --------------------------------------------------------------------
// generator
// --------------------------------------------------------------------
// Function
// - after arming, wait delay source edges, then one pulse of width.
// - count only on the selected rising or falling source edge.
// - triggered single pulse starts its delay at the start trigger.
// - pulse counter stops a finite train at the programmed count.
// - retrigger mode: each trigger launches one generation; busy ignores gate.
// - flag selects initial delay on every retrigger or only the first.
// - after a retriggered generation, wait again for a start trigger.
// - pause gate use is rejected when retriggering is selected.
// - continuous train alternates high and low widths after the delay.
// - continuous train starts at arming or at a gate start trigger.
// - pause gate freezes output progress while it is active.
// - output frequency is source frequency divided by high plus low.
// - implicit buffered: one pulse per sample, back to back.
// - finite implicit generation ends after the supplied samples.
// - implicit buffered mode ignores the static pulse settings.
// - sample clocked mode runs static settings until first sample clock.
// - sample clock takes effect after the current idle/active pulse.
// - finite sample clocked run repeats the last spec until stopped.
// - continuous sample clocked runs go on until an explicit stop; implicit ones end when no sample is ready.
// - fifo regeneration replays loaded samples cyclically, no host writes.
// - non-regenerating supply that falls behind flags underflow.
module cptg_generator
  import cptg_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // control and configuration
  input wire logic arm_i,
  input wire logic stop_i,
  input wire cptg_cfg_s cfg_i,
  // pins
  input wire logic source_i,
  input wire logic gate_i,
  input wire logic sample_clk_i,
  // sample stream
  input wire logic spec_valid_i,
  output logic spec_ready_o,
  input wire cptg_spec_s spec_i,
  // outputs and status
  output logic pulse_o,
  output logic busy_o,
  output logic done_o,
  output logic underflow_o,
  output logic cfg_error_o
);

  typedef struct packed {
    logic [1:0] src_sync;
    logic [1:0] gate_sync;
    logic [1:0] sclk_sync;
    logic src_prev;
    logic gate_prev;
    logic sclk_prev;
    cptg_state_e state;
    logic [CPTG_CNT_W-1:0] count;
    logic [CPTG_CNT_W-1:0] pulses;
    logic [CPTG_CNT_W-1:0] cur_low;
    logic [CPTG_CNT_W-1:0] cur_high;
    logic first_done;
    logic sclk_pending;
    logic sclk_seen;
    logic [CPTG_PTR_W:0] replay_left;
    logic [CPTG_PTR_W:0] regen_len;
    logic pulse;
    logic done;
    logic underflow;
  } cptg_core_s;

  cptg_core_s st;
  cptg_core_s next_st;
  logic src_edge;
  logic gate_rise;
  logic sclk_rise;
  logic buffered;
  logic cfg_bad;
  logic pause;
  logic fifo_in_valid;
  logic fifo_in_ready;
  cptg_spec_s fifo_in_data;
  logic fifo_out_valid;
  logic fifo_out_ready;
  cptg_spec_s fifo_out_data;
  logic [CPTG_PTR_W:0] fifo_level;
  logic take;
  logic recycle;

  assign buffered = (cfg_i.mode == CPTG_MODE_IMPLICIT)
                 || (cfg_i.mode == CPTG_MODE_SAMPCLK);
  assign cfg_bad = cfg_i.retrigger && (cfg_i.gate_use == CPTG_GATE_PAUSE);
  assign src_edge = cfg_i.src_falling ? (st.src_prev && !st.src_sync[1])
                                      : (!st.src_prev && st.src_sync[1]);
  assign gate_rise = !st.gate_prev && st.gate_sync[1];
  assign sclk_rise = !st.sclk_prev && st.sclk_sync[1];
  assign pause = (cfg_i.gate_use == CPTG_GATE_PAUSE) && !cfg_i.retrigger
              && st.gate_sync[1];

  // fifo regeneration feeds popped samples back in; host writes blocked
  assign recycle = cfg_i.supply == CPTG_SUP_FIFO_REGEN
                && (st.state != CPTG_ST_OFF || take);
  assign fifo_in_valid = recycle ? take : spec_valid_i;
  assign fifo_in_data = recycle ? fifo_out_data : spec_i;
  assign spec_ready_o = recycle ? 1'b0 : fifo_in_ready;

  cptg_fifo #(
    .WIDTH(CPTG_SPEC_W),
    .DEPTH(CPTG_FIFO_DEPTH),
    .PTR_W(CPTG_PTR_W)
  ) u_fifo (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .flush_i(1'b0),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(fifo_in_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data),
    .level_o(fifo_level)
  );

  // a sample is consumed at implicit arming and at the end of each active
  // phase when it applies
  always_comb begin
    take = 1'b0;
    if (st.state == CPTG_ST_OFF && arm_i && !cfg_bad && !stop_i
        && cfg_i.mode == CPTG_MODE_IMPLICIT) begin
      take = fifo_out_valid;
    end
    if (buffered && st.state == CPTG_ST_HIGH && src_edge && !pause
        && st.count <= CPTG_ONE) begin
      if (cfg_i.mode == CPTG_MODE_IMPLICIT) begin
        take = fifo_out_valid;
      end else begin
        take = fifo_out_valid && (st.sclk_pending || sclk_rise);
      end
    end
  end
  assign fifo_out_ready = take;

  always_comb begin
    next_st = st;
    next_st.src_sync = {st.src_sync[0], source_i};
    next_st.gate_sync = {st.gate_sync[0], gate_i};
    next_st.sclk_sync = {st.sclk_sync[0], sample_clk_i};
    next_st.src_prev = st.src_sync[1];
    next_st.gate_prev = st.gate_sync[1];
    next_st.sclk_prev = st.sclk_sync[1];
    if (sclk_rise && st.state != CPTG_ST_OFF) begin
      next_st.sclk_pending = 1'b1;
      next_st.sclk_seen = 1'b1;
    end
    case (st.state)
      CPTG_ST_OFF: begin
        next_st.pulse = 1'b0;
        if (arm_i && !cfg_bad) begin
          next_st.done = 1'b0;
          next_st.underflow = 1'b0;
          next_st.first_done = 1'b0;
          next_st.sclk_pending = 1'b0;
          next_st.sclk_seen = 1'b0;
          next_st.pulses = CPTG_ZERO;
          next_st.regen_len = fifo_level;
          next_st.cur_low = cfg_i.low_ticks;
          next_st.cur_high = cfg_i.high_ticks;
          next_st.count = cfg_i.init_delay;
          if (cfg_i.mode == CPTG_MODE_IMPLICIT) begin
            // static settings unused; first sample sets the pulse
            next_st.count = fifo_out_data.idle_ticks;
            next_st.cur_high = fifo_out_data.active_ticks;
            next_st.state = CPTG_ST_LOW;
            next_st.replay_left = fifo_level;
          end else if (cfg_i.gate_use == CPTG_GATE_START || cfg_i.retrigger) begin
            next_st.state = CPTG_ST_WAIT;
          end else begin
            next_st.state = CPTG_ST_DELAY;
          end
        end
      end
      CPTG_ST_WAIT: begin
        next_st.pulse = 1'b0;
        if (gate_rise) begin
          next_st.pulses = CPTG_ZERO;
          if (st.first_done && !cfg_i.delay_on_every_trigger) begin
            next_st.count = st.cur_low;
            next_st.state = CPTG_ST_LOW;
          end else begin
            next_st.count = cfg_i.init_delay;
            next_st.state = CPTG_ST_DELAY;
          end
        end
      end
      CPTG_ST_DELAY, CPTG_ST_LOW: begin
        next_st.pulse = 1'b0;
        if (src_edge && !pause) begin
          if (st.count <= CPTG_ONE) begin
            next_st.count = st.cur_high;
            next_st.state = CPTG_ST_HIGH;
          end else begin
            next_st.count = st.count - CPTG_ONE;
          end
        end
      end
      CPTG_ST_HIGH: begin
        next_st.pulse = 1'b1;
        if (src_edge && !pause) begin
          if (st.count > CPTG_ONE) begin
            next_st.count = st.count - CPTG_ONE;
          end else begin
            // one full period of high plus low ticks ends here
            next_st.pulse = 1'b0;
            next_st.pulses = st.pulses + CPTG_ONE;
            next_st.count = st.cur_low;
            next_st.state = CPTG_ST_LOW;
            if (take) begin
              next_st.cur_low = fifo_out_data.idle_ticks;
              next_st.cur_high = fifo_out_data.active_ticks;
              next_st.count = fifo_out_data.idle_ticks;
              // a new sample clock edge in this cycle stays pending only if an older one was pending
              next_st.sclk_pending = st.sclk_pending && sclk_rise;
              next_st.replay_left = st.replay_left - CPTG_LVL_ONE;
            end
            case (cfg_i.mode)
              CPTG_MODE_SINGLE: begin
                next_st.state = CPTG_ST_DONE;
              end
              CPTG_MODE_FINITE: begin
                if (st.pulses + CPTG_ONE >= cfg_i.pulse_count) begin
                  next_st.state = CPTG_ST_DONE;
                end
              end
              CPTG_MODE_IMPLICIT: begin
                if (cfg_i.finite_buf && cfg_i.supply != CPTG_SUP_FIFO_REGEN
                    && !fifo_out_valid) begin
                  next_st.state = CPTG_ST_DONE;
                end else if (cfg_i.finite_buf
                             && cfg_i.supply == CPTG_SUP_FIFO_REGEN
                             && st.replay_left <= CPTG_LVL_ONE) begin
                  next_st.state = CPTG_ST_DONE;
                end else if (!take) begin
                  next_st.underflow = st.underflow
                    || cfg_i.supply == CPTG_SUP_NONREGEN;
                  next_st.state = CPTG_ST_DONE;
                end
              end
              CPTG_MODE_SAMPCLK: begin
                // no sample or no clock: repeat last spec
                if (!take && st.sclk_pending && !cfg_i.finite_buf
                    && cfg_i.supply == CPTG_SUP_NONREGEN) begin
                  next_st.underflow = 1'b1;
                end
                next_st.state = CPTG_ST_LOW;
              end
              default: begin
                next_st.state = CPTG_ST_LOW;
              end
            endcase
          end
        end
      end
      CPTG_ST_DONE: begin
        next_st.pulse = 1'b0;
        next_st.first_done = 1'b1;
        if (cfg_i.retrigger) begin
          next_st.state = CPTG_ST_WAIT;
        end else begin
          next_st.done = 1'b1;
          next_st.state = CPTG_ST_OFF;
        end
      end
      default: begin
        next_st.state = CPTG_ST_OFF;
      end
    endcase
    if (stop_i) begin
      next_st.state = CPTG_ST_OFF;
      next_st.pulse = 1'b0;
    end
  end

  // gate edges only matter in wait state, so busy generations ignore them
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pulse_o = st.pulse;
  assign busy_o = st.state != CPTG_ST_OFF;
  assign done_o = st.done;
  assign underflow_o = st.underflow;
  assign cfg_error_o = cfg_bad;
endmodule

// ===== verification/cptg_generator_props.sv
// cptg_generator_props: port-level checks of the pulse train generator
// assumes: bound to cptg_generator; pins change only after clock_i edges
`timescale 1ns/1ps
module cptg_generator_props
  import cptg_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // control and pins
  input wire logic arm_i,
  input wire logic stop_i,
  input wire cptg_cfg_s cfg_i,
  input wire logic source_i,
  input wire logic gate_i,
  // outputs
  input wire logic spec_ready_o,
  input wire logic pulse_o,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic underflow_o,
  input wire logic cfg_error_o
);
  // --------------------------------------------------------------
  // age of the last selected source edge and of a high gate
  // --------------------------------------------------------------
  logic src_q;
  logic [3:0] src_age;
  logic [3:0] gate_age;
  wire sel_edge = cfg_i.src_falling ? (src_q & ~source_i) :
    (~src_q & source_i);
  always_ff @(posedge clock_i) begin
    src_q <= source_i;
    if (reset_i || sel_edge) src_age <= 4'h0;
    else if (src_age != 4'hf) src_age <= src_age + 4'h1;
    if (reset_i || !gate_i) gate_age <= 4'h0;
    else if (gate_age != 4'hf) gate_age <= gate_age + 4'h1;
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  a_cfg_error_flag: assert property (
    cfg_error_o == (cfg_i.retrigger && cfg_i.gate_use == CPTG_GATE_PAUSE))
    else $error("cfg error flag wrong");
  a_bad_arm_refused: assert property (
    arm_i && !busy_o && cfg_error_o |=> !busy_o)
    else $error("arm taken with bad config");
  a_arm_taken: assert property (
    arm_i && !busy_o && !cfg_error_o && !stop_i |=>
    busy_o && !done_o && !underflow_o)
    else $error("arm not taken");
  a_busy_from_arm: assert property (
    $rose(busy_o) |-> $past(arm_i))
    else $error("busy without arm");
  a_stop_idles: assert property (
    stop_i |=> !busy_o && !pulse_o)
    else $error("stop did not idle");
  a_idle_low: assert property (
    !busy_o |-> !pulse_o)
    else $error("pulse active while idle");
  a_edge_paced: assert property (
    $changed(pulse_o) && !$past(stop_i) |-> src_age <= 4'h6)
    else $error("pulse moved off a source edge");
  a_pause_holds: assert property (
    cfg_i.gate_use == CPTG_GATE_PAUSE && gate_age > 4'h8 |->
    $stable(pulse_o))
    else $error("pulse moved while paused");
  a_regen_no_host: assert property (
    busy_o && cfg_i.supply == CPTG_SUP_FIFO_REGEN |-> !spec_ready_o)
    else $error("host sample taken during regeneration");
endmodule

bind cptg_generator cptg_generator_props u_props (.clock_i, .reset_i,
  .arm_i, .stop_i, .cfg_i, .source_i, .gate_i, .spec_ready_o, .pulse_o,
  .busy_o, .done_o, .underflow_o, .cfg_error_o);

// ===== verification/cptg_generator_bench.sv
// cptg_generator_bench: directed scenarios for the pulse train generator
// assumes: bench drives every pin; source has an edge every 10 clocks
`timescale 1ns/1ps
module cptg_generator_bench
  import cptg_pkg::*;
;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic arm_i = 1'b0;
  logic stop_i = 1'b0;
  logic source_i = 1'b0;
  logic gate_i = 1'b0;
  logic sample_clk_i = 1'b0;
  logic spec_valid_i = 1'b0;
  cptg_cfg_s cfg_i = '0;
  cptg_spec_s spec_i = '0;
  logic spec_ready_o, pulse_o, busy_o, done_o, underflow_o, cfg_error_o;
  int mismatches = 0;
  int checks = 0;
  int edges = 0;
  int sdiv = 0;

  always #12.5 clock_i = ~clock_i;
  // source timebase; edges counts the selected ones
  always @(posedge clock_i) begin
    sdiv <= (sdiv == 9) ? 0 : sdiv + 1;
    if (sdiv == 9) begin
      source_i <= ~source_i;
      if (source_i == cfg_i.src_falling) edges <= edges + 1;
    end
  end

  cptg_generator uut (.clock_i, .reset_i, .arm_i, .stop_i, .cfg_i,
    .source_i, .gate_i, .sample_clk_i, .spec_valid_i, .spec_ready_o,
    .spec_i, .pulse_o, .busy_o, .done_o, .underflow_o, .cfg_error_o);

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic tick(int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wait_pulse(logic lvl);
    int k;
    for (k = 0; k < 4000 && pulse_o !== lvl; k++) tick(1);
    if (k == 4000) begin
      check("pulse level reached", 1, 0);
      complete_run();
    end
  endtask
  task automatic sync_src();
    int e;
    int k;
    e = edges;
    for (k = 0; k < 30 && e == edges; k++) tick(1);
    if (e == edges) begin
      check("source edge seen", 1, 0);
      complete_run();
    end
    tick(5);
  endtask
  // flags f: falling, retrigger, delay on every trigger, finite buffer
  task automatic setcfg(cptg_mode_e m, cptg_gate_e g, cptg_sup_e s,
      logic [3:0] f, logic [31:0] d, logic [31:0] lo, logic [31:0] hi,
      logic [31:0] n);
    cfg_i <= '{m, g, s, f[3], f[2], f[1], f[0], d, lo, hi, n};
    tick(2);
  endtask
  task automatic arm_go(output int e);
    sync_src();
    e = edges;
    arm_i <= 1'b1;
    tick(1);
    arm_i <= 1'b0;
    tick(1);
  endtask
  task automatic gate_go(output int e);
    sync_src();
    e = edges;
    gate_i <= 1'b1;
    tick(4);
    gate_i <= 1'b0;
  endtask
  task automatic stop_go();
    stop_i <= 1'b1;
    tick(1);
    stop_i <= 1'b0;
    tick(2);
  endtask
  task automatic sclk_go();
    sample_clk_i <= 1'b1;
    tick(4);
    sample_clk_i <= 1'b0;
  endtask
  task automatic width(output int w);
    int e;
    wait_pulse(1'b1);
    e = edges;
    wait_pulse(1'b0);
    w = edges - e;
  endtask
  // counts rises while busy; per is edges between first two rises
  task automatic run(int lim, output int n, output int per);
    int e;
    logic p;
    n = 0;
    per = 0;
    e = 0;
    p = pulse_o;
    for (int k = 0; k < lim && busy_o === 1'b1; k++) begin
      tick(1);
      if (pulse_o === 1'b1 && p === 1'b0) begin
        n++;
        if (n == 2) per = edges - e;
        e = edges;
      end
      p = pulse_o;
    end
  endtask
  // sample k carries one idle tick and k%3+1 active ticks
  task automatic fill(int lim, output int n);
    n = 0;
    spec_valid_i <= 1'b1;
    spec_i <= '{CPTG_ONE, CPTG_ONE};
    for (int k = 0; k < lim; k++) begin
      tick(1);
      if (spec_ready_o === 1'b1) begin
        n++;
        spec_i <= '{CPTG_ONE, 32'(n % 3 + 1)};
      end
    end
    spec_valid_i <= 1'b0;
    tick(1);
  endtask

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_single(logic fall, int d, int wid);
    int e, w;
    setcfg(CPTG_MODE_SINGLE, CPTG_GATE_NONE, CPTG_SUP_HOST, {fall, 3'h0},
      32'(d), CPTG_ONE, 32'(wid), CPTG_ONE);
    arm_go(e);
    wait_pulse(1'b1);
    check("delay edges", d, edges - e);
    width(w);
    check("width edges", wid, w);
    tick(3);
    check("single done", 1, done_o);
  endtask
  task automatic t_trig();
    int e, w;
    setcfg(CPTG_MODE_SINGLE, CPTG_GATE_START, CPTG_SUP_HOST, 4'h0, 32'd3,
      CPTG_ONE, 32'd2, CPTG_ONE);
    arm_go(e);
    tick(80);
    check("waiting pulse", 0, pulse_o);
    check("waiting busy", 1, busy_o);
    gate_go(e);
    wait_pulse(1'b1);
    check("trigger delay", 3, edges - e);
    width(w);
    check("trigger width", 2, w);
  endtask
  task automatic t_retrig(logic every);
    int e, n, p, d;
    setcfg(CPTG_MODE_SINGLE, CPTG_GATE_START, CPTG_SUP_HOST,
      {2'b01, every, 1'b0}, 32'd2, CPTG_ONE, 32'd3, CPTG_ONE);
    arm_go(e);
    for (int k = 0; k < 2; k++) begin
      d = (every || k == 0) ? 2 : 1;
      gate_go(e);
      wait_pulse(1'b1);
      check("retrigger delay", d, edges - e);
      e = edges;
      gate_go(p);
      wait_pulse(1'b0);
      check("retrigger width", 3, edges - e);
      run(300, n, p);
      check("gate ignored", 0, n);
      check("rewaiting", 1, busy_o);
    end
    stop_go();
  endtask
  task automatic t_bad();
    int e;
    setcfg(CPTG_MODE_SINGLE, CPTG_GATE_PAUSE, CPTG_SUP_HOST, 4'h4, 32'd2,
      CPTG_ONE, 32'd2, CPTG_ONE);
    check("cfg error", 1, cfg_error_o);
    arm_go(e);
    check("arm refused", 0, busy_o);
  endtask
  task automatic t_finite();
    int e, n, p;
    setcfg(CPTG_MODE_FINITE, CPTG_GATE_NONE, CPTG_SUP_HOST, 4'h0, CPTG_ONE,
      32'd3, 32'd2, 32'd4);
    arm_go(e);
    run(3000, n, p);
    check("train pulses", 4, n);
    check("train period", 5, p);
    check("train done", 1, done_o);
  endtask
  task automatic t_cont();
    int e, n, p;
    setcfg(CPTG_MODE_CONT, CPTG_GATE_PAUSE, CPTG_SUP_FIFO_REGEN, 4'h0,
      32'd2, 32'd2, 32'd3, CPTG_ONE);
    arm_go(e);
    run(600, n, p);
    check("cont period", 5, p);
    check("cont running", 1, busy_o);
    gate_i <= 1'b1;
    tick(10);
    run(300, n, p);
    check("paused rises", 0, n);
    gate_i <= 1'b0;
    tick(100);
    stop_go();
    check("stopped pulse", 0, pulse_o);
    check("stopped busy", 0, busy_o);
  endtask
  task automatic t_implicit();
    int e, n, w;
    setcfg(CPTG_MODE_IMPLICIT, CPTG_GATE_NONE, CPTG_SUP_HOST, 4'h1, 32'd5,
      32'd5, 32'd7, 32'd9);
    fill(40, n);
    check("fifo accepted", CPTG_FIFO_DEPTH, n);
    arm_go(e);
    for (int k = 0; k < 32; k++) begin
      width(w);
      check("sample width", k % 3 + 1, w);
    end
    check("implicit span", 95, edges - e);
    tick(60);
    check("implicit done", 1, done_o);
  endtask
  task automatic t_underflow();
    int e, n, p;
    setcfg(CPTG_MODE_IMPLICIT, CPTG_GATE_NONE, CPTG_SUP_NONREGEN, 4'h0,
      CPTG_ONE, CPTG_ONE, CPTG_ONE, CPTG_ONE);
    fill(2, n);
    arm_go(e);
    run(3000, n, p);
    check("starved pulses", 2, n);
    check("underflow", 1, underflow_o);
  endtask
  task automatic t_sampclk();
    int e, n, w;
    setcfg(CPTG_MODE_SAMPCLK, CPTG_GATE_NONE, CPTG_SUP_HOST, 4'h1, 32'd2,
      32'd2, 32'd2, CPTG_ONE);
    fill(2, n);
    arm_go(e);
    wait_pulse(1'b1);
    check("clocked delay", 2, edges - e);
    width(w);
    check("static width", 2, w);
    sclk_go();
    width(w);
    check("pulse finished", 2, w);
    width(w);
    check("first sample", 1, w);
    width(w);
    check("spec held", 1, w);
    sclk_go();
    width(w);
    check("held pulse finished", 1, w);
    width(w);
    check("last sample", 2, w);
    width(w);
    check("last repeated", 2, w);
    check("still running", 1, busy_o);
    stop_go();
  endtask
  task automatic t_regen();
    int e, n, w;
    setcfg(CPTG_MODE_IMPLICIT, CPTG_GATE_NONE, CPTG_SUP_FIFO_REGEN, 4'h0,
      CPTG_ONE, CPTG_ONE, CPTG_ONE, CPTG_ONE);
    fill(3, n);
    arm_go(e);
    for (int k = 0; k < 6; k++) begin
      width(w);
      check("replay width", k % 3 + 1, w);
    end
    check("host blocked", 0, spec_ready_o);
    stop_go();
  endtask

  initial begin
    tick(16);
    reset_i <= 1'b0;
    tick(1);
    t_single(1'b0, 4, 3);
    t_single(1'b1, 2, 5);
    t_trig();
    t_retrig(1'b1);
    t_retrig(1'b0);
    t_bad();
    t_finite();
    t_cont();
    t_implicit();
    t_underflow();
    t_sampclk();
    t_regen();
    complete_run();
  end
endmodule
